// [verilog/system_clock_mode_controller.v]
// system clock and operating mode controller with an ahb-lite register slave
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "clock_mode_regs.vh"

// What this block does
// R1: two-stage prescaler then twenty-one-stage divider
// R2: reset and stop entry/release clear dividers
// R3: stage seven source from mode and selects
// R4: low modes feed slow clock to seven
// R5: warm-up after fast stop uses stage six
// R6: software keeps stage-seven select off single-clock
// R7: machine cycle is four main clock states
// R8: single clock runs fast only, pins general
// R9: reset starts in fast single run mode
// R10: idle bit halts; interrupt returns to run
// R11: release services interrupt or resumes next
// R12: timing halt gates peripherals until tick edge
// R13: deep halt ignores enable, latches tick
// R14: dual clock: both oscillators, mode picks clock
// R15: software starts slow oscillator for dual use
// R16: main select toggles fast dual/low fast-on
// R17: fast enable toggles low fast-on/fast-off
// R18: software keeps slow oscillator on in low
// R19: low fast-off and low sleeps stop stages one-six
// R20: fast dual halt returns to dual run
// R21: low halt fast-off returns to low run
// R22: low halt fast-on keeps fast oscillator
// R23: deep low halt returns on tick edge
// R24: stop by bit, released by pin
// R25: clock switching and gating glitch-free
module system_clock_mode_controller #(
   parameter WARMUP_STAGE = `WARMUP_STAGE   // divider stage ending warm-up
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        fast_clock,        // fast oscillator output
   input  wire        slow_clock,        // slow oscillator output
   input  wire        stop_pin_n,        // stop release pin
   input  wire        irq_request,       // any peripheral or external request
   output reg         main_clk_en,       // one pulse per main system clock
   output reg  [1:0]  machine_state,     // S0..S3
   output reg         cpu_run,
   output reg         periph_clk_en,     // gated peripheral clock enable
   output reg         tick_clk_en,       // tick timer clock enable
   output reg  [22:0] divider_taps,      // prescaler and divider outputs
   output wire        fast_osc_on,
   output wire        slow_osc_on,
   output wire        xtal_pins_general,
   output reg         irq_accept,        // pulse: service interrupt on release
   output reg         resume_next,       // pulse: continue after halt instruction
   output wire        tick_irq_service
);

////////////////////////////////////////////////////////////////////////
// modes
localparam [3:0] FAST_RUN_SINGLE   = 4'h0;
localparam [3:0] FAST_HALT_SINGLE  = 4'h1;
localparam [3:0] DEEP_HALT_FAST    = 4'h2;
localparam [3:0] FAST_RUN_DUAL     = 4'h3;
localparam [3:0] FAST_HALT_DUAL    = 4'h4;
localparam [3:0] LOW_RUN_FAST_ON   = 4'h5;
localparam [3:0] LOW_RUN_FAST_OFF  = 4'h6;
localparam [3:0] LOW_HALT_FAST_ON  = 4'h7;
localparam [3:0] LOW_HALT_FAST_OFF = 4'h8;
localparam [3:0] DEEP_HALT_LOW     = 4'h9;
localparam [3:0] STOP_MODE         = 4'hA;
localparam [3:0] WARM_UP           = 4'hB;

reg  [3:0]  mode;                 // operating mode
reg  [3:0]  next_mode;
reg         warm_from_fast;       // stop was entered from a fast mode
reg         tick_en_at_entry;     // tick enable seen at deep halt entry
reg         tick_irq_latch;
reg         low_source;           // registered main clock source
reg         release_pulse;        // halt released this cycle

// software bits
reg         stop_start;
reg         release_level;
reg         return_slow;
reg         fast_osc_enable;
reg         slow_osc_enable;
reg         main_clock_select;
reg  [7:0]  tick_timer_control;
reg         master_irq_enable;
reg         tick_irq_enable;

////////////////////////////////////////////////////////////////////////
// pin synchronisers; the fast clock must stay below half of hclk
reg  [2:0]  fast_sync;
reg  [2:0]  slow_sync;
reg  [2:0]  stop_sync;
wire        fast_tick = fast_sync[1] & ~fast_sync[2];
wire        slow_tick = slow_sync[1] & ~slow_sync[2];
wire        stop_level = ~stop_sync[1];
wire        stop_edge  = ~stop_sync[1] & stop_sync[2];

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      fast_sync <= 3'h0;
      slow_sync <= 3'h0;
      stop_sync <= 3'h7;
   end else begin
      fast_sync <= {fast_sync[1:0], fast_clock};
      slow_sync <= {slow_sync[1:0], slow_clock};
      stop_sync <= {stop_sync[1:0], stop_pin_n};
   end
end

////////////////////////////////////////////////////////////////////////
// mode groups
wire low_mode  = (mode == LOW_RUN_FAST_ON) || (mode == LOW_RUN_FAST_OFF) ||
                 (mode == LOW_HALT_FAST_ON) || (mode == LOW_HALT_FAST_OFF) ||
                 (mode == DEEP_HALT_LOW);
wire deep_halt = (mode == DEEP_HALT_FAST) || (mode == DEEP_HALT_LOW);
wire frozen    = (mode == STOP_MODE);
// stages one to six idle in low run fast-off and in the three low halt modes
wire low_stop16 = (mode == LOW_RUN_FAST_OFF) || (mode == LOW_HALT_FAST_OFF) ||
                  (mode == LOW_HALT_FAST_ON) || (mode == DEEP_HALT_LOW);

// R8: single clock frees the slow crystal pins
assign xtal_pins_general = ~slow_osc_enable;
// R14: both oscillators run in dual operation
assign slow_osc_on = slow_osc_enable & ~frozen;
assign fast_osc_on = fast_osc_enable & ~frozen;

////////////////////////////////////////////////////////////////////////
// prescaler and divider chain, stepped by clock enables
reg  [1:0]  prescaler;
reg  [20:0] divider;
reg         s6_carry;
reg         s7_in;

// R1: carry out of stage six, driven by the fast clock
always @* begin
   s6_carry = fast_tick & (&prescaler) & (&divider[5:0]) & ~low_stop16;
end

// R3: stage seven input selection
always @* begin
   if (low_mode) begin
      // R4: slow clock straight into stage seven
      s7_in = slow_tick;
   end else if (mode == WARM_UP && warm_from_fast) begin
      // R5: stage six drives seven during warm-up
      s7_in = s6_carry;
   end else if (tick_timer_control[`BIT_STAGE7_SEL]) begin
      s7_in = slow_tick;
   end else begin
      s7_in = s6_carry;
   end
end

// divider counting; cleared on stop entry and release
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      // R2: reset clears the whole chain
      prescaler <= 2'h0;
      divider   <= 21'h000000;
   end else if ((next_mode == STOP_MODE) != frozen) begin
      // R2: cleared entering and leaving stop
      prescaler <= 2'h0;
      divider   <= 21'h000000;
   end else if (!frozen) begin
      // R19: stages one to six halt in slow sleep
      if (fast_tick && !low_stop16) begin
         prescaler    <= prescaler + 2'h1;
         if (&prescaler)
            divider[5:0] <= divider[5:0] + 6'h01;
      end
      if (s7_in)
         divider[20:6] <= divider[20:6] + 15'h0001;
   end
end

////////////////////////////////////////////////////////////////////////
// main system clock; source changes only at a machine cycle end or while stopped
wire src_tick = low_source ? slow_tick : fast_tick;
wire want_low = low_mode;
// a tick right behind a pulse is dropped, so a source swap never doubles up
wire main_tick = src_tick & ~frozen & ~main_clk_en;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      low_source    <= 1'b0;
      main_clk_en   <= 1'b0;
      machine_state <= 2'h0;
      divider_taps  <= 23'h000000;
   end else begin
      divider_taps <= {divider, prescaler};
      main_clk_en  <= main_tick;
      // R7: four states, one main clock each
      if (main_tick)
         machine_state <= machine_state + 2'h1;
      // R25: swap source only after S3 or in stop, no short pulses
      if ((main_tick && machine_state == 2'h3) || frozen)
         low_source <= want_low;
   end
end

////////////////////////////////////////////////////////////////////////
// tick source edge for deep halt wake-up
reg        tick_src_prev;
reg        tick_src;
always @* begin
   case (tick_timer_control[2:0])
      3'h0:    tick_src = divider[20];
      3'h1:    tick_src = divider[18];
      3'h2:    tick_src = divider[13];
      3'h3:    tick_src = divider[11];
      3'h4:    tick_src = divider[10];
      3'h5:    tick_src = divider[9];
      3'h6:    tick_src = divider[8];
      default: tick_src = divider[6];
   endcase
end
wire tick_fall = tick_src_prev & ~tick_src;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn)
      tick_src_prev <= 1'b0;
   else
      tick_src_prev <= tick_src;
end

////////////////////////////////////////////////////////////////////////
// bus write decode
reg        wr_pend;
reg  [7:0] wr_addr;
wire       addr_ok = hsel & hready & htrans[1];
wire       wr_two  = wr_pend && wr_addr == `OFS_SYS_CONTROL_TWO;
wire       idle_req = wr_two && hwdata[`BIT_IDLE];
wire       tg_req   = wr_two && hwdata[`BIT_TG_HALT];
wire       stop_req = wr_pend && wr_addr == `OFS_SYS_CONTROL_ONE &&
                      hwdata[`BIT_STOP_START];
wire       stop_release = release_level ? stop_level : stop_edge;

////////////////////////////////////////////////////////////////////////
// operating mode sequencer
always @* begin
   next_mode = mode;
   case (mode)
      FAST_RUN_SINGLE, FAST_RUN_DUAL: begin
         if (stop_req)
            next_mode = STOP_MODE;
         // R12: timing halt in fast operation
         else if (tg_req)
            next_mode = DEEP_HALT_FAST;
         // R10: idle write halts the cpu
         else if (idle_req)
            next_mode = slow_osc_enable ? FAST_HALT_DUAL : FAST_HALT_SINGLE;
         // R16: main select moves to low run
         else if (slow_osc_enable && main_clock_select)
            next_mode = LOW_RUN_FAST_ON;
         else
            next_mode = slow_osc_enable ? FAST_RUN_DUAL : FAST_RUN_SINGLE;
      end
      LOW_RUN_FAST_ON, LOW_RUN_FAST_OFF: begin
         if (stop_req)
            next_mode = STOP_MODE;
         // R23: timing halt in low operation
         else if (tg_req)
            next_mode = DEEP_HALT_LOW;
         else if (idle_req)
            next_mode = fast_osc_enable ? LOW_HALT_FAST_ON : LOW_HALT_FAST_OFF;
         // R16: main select cleared goes back to fast dual
         else if (!main_clock_select && mode == LOW_RUN_FAST_ON)
            next_mode = FAST_RUN_DUAL;
         // R17: fast enable picks fast-on or fast-off
         else
            next_mode = fast_osc_enable ? LOW_RUN_FAST_ON : LOW_RUN_FAST_OFF;
      end
      // R10: any request releases the halt
      FAST_HALT_SINGLE:  if (irq_request) next_mode = FAST_RUN_SINGLE;
      // R20: dual halt returns to dual run
      FAST_HALT_DUAL:    if (irq_request) next_mode = FAST_RUN_DUAL;
      // R21: back to low run fast-off
      LOW_HALT_FAST_OFF: if (irq_request) next_mode = LOW_RUN_FAST_OFF;
      // R22: keeps the fast oscillator while halted
      LOW_HALT_FAST_ON:  if (irq_request) next_mode = LOW_RUN_FAST_ON;
      // R12: wake on selected tick falling edge
      DEEP_HALT_FAST:
         if (tick_fall) next_mode = slow_osc_enable ? FAST_RUN_DUAL : FAST_RUN_SINGLE;
      // R23: low deep halt wakes to low fast-off
      DEEP_HALT_LOW:     if (tick_fall) next_mode = LOW_RUN_FAST_OFF;
      // R24: pin releases stop, level or edge
      STOP_MODE:         if (stop_release) next_mode = WARM_UP;
      WARM_UP:
         if (divider[WARMUP_STAGE - 7])
            next_mode = return_slow ? LOW_RUN_FAST_OFF :
                        (slow_osc_enable ? FAST_RUN_DUAL : FAST_RUN_SINGLE);
      default:           next_mode = FAST_RUN_SINGLE;
   endcase
end

// mode register and release bookkeeping
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      // R9: reset lands in fast single run
      mode             <= FAST_RUN_SINGLE;
      warm_from_fast   <= 1'b0;
      tick_en_at_entry <= 1'b0;
      release_pulse    <= 1'b0;
   end else begin
      mode <= next_mode;
      if (next_mode == STOP_MODE && !frozen)
         warm_from_fast <= ~low_mode;
      // R13: capture tick enable, entry ignores it
      if ((next_mode == DEEP_HALT_FAST || next_mode == DEEP_HALT_LOW) && !deep_halt)
         tick_en_at_entry <= tick_timer_control[`BIT_TICK_EN];
      release_pulse <= (~cpu_mode(mode) & cpu_mode(next_mode)) &
                       (mode != WARM_UP);
   end
end

// cpu runs in run modes and after warm-up
function cpu_mode;
   input [3:0] m;
   begin
      cpu_mode = (m == FAST_RUN_SINGLE) || (m == FAST_RUN_DUAL) ||
                 (m == LOW_RUN_FAST_ON) || (m == LOW_RUN_FAST_OFF);
   end
endfunction

////////////////////////////////////////////////////////////////////////
// cpu and peripheral gating, release outcome
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      cpu_run       <= 1'b1;
      periph_clk_en <= 1'b0;
      tick_clk_en   <= 1'b0;
      irq_accept    <= 1'b0;
      resume_next   <= 1'b0;
   end else begin
      cpu_run       <= cpu_mode(next_mode);
      // R25: gate on main clock pulses only, never mid-pulse
      periph_clk_en <= main_tick & ~deep_halt & (mode != WARM_UP);
      tick_clk_en   <= main_tick;
      // R11: service first, or fall through
      irq_accept    <= release_pulse & master_irq_enable;
      resume_next   <= release_pulse & ~master_irq_enable;
   end
end

// R13: service needs all three enables
assign tick_irq_service = tick_irq_latch & master_irq_enable &
                          tick_irq_enable & tick_timer_control[`BIT_TICK_EN];

////////////////////////////////////////////////////////////////////////
// ahb-lite slave: zero wait, always okay
assign hreadyout = 1'b1;
assign hresp     = 1'b0;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
   end else begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr;
      if (addr_ok && !hwrite) begin
         case (haddr)
            `OFS_SYS_CONTROL_ONE:
               hrdata <= {24'h000000, stop_start, release_level, return_slow, 5'h00};
            `OFS_SYS_CONTROL_TWO:
               hrdata <= {24'h000000, fast_osc_enable, slow_osc_enable,
                          main_clock_select, 5'h00};
            `OFS_TICK_CONTROL: hrdata <= {24'h000000, tick_timer_control};
            `OFS_IRQ_CONTROL:
               hrdata <= {30'h00000000, tick_irq_enable, master_irq_enable};
            `OFS_STATUS:
               hrdata <= {23'h000000, tick_irq_latch, 2'h0, machine_state, mode};
            default: hrdata <= 32'h00000000;   // unmapped reads zero
         endcase
      end
   end
end

// register storage; idle and halt bits act as write strobes
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      stop_start         <= 1'b0;
      release_level      <= 1'b0;
      return_slow        <= 1'b0;
      fast_osc_enable    <= 1'b1;
      slow_osc_enable    <= 1'b0;
      main_clock_select  <= 1'b0;
      tick_timer_control <= 8'h00;
      master_irq_enable  <= 1'b0;
      tick_irq_enable    <= 1'b0;
      tick_irq_latch     <= 1'b0;
   end else begin
      if (wr_pend && wr_addr == `OFS_SYS_CONTROL_ONE) begin
         release_level <= hwdata[`BIT_RELEASE_LEVEL];
         return_slow   <= hwdata[`BIT_RETURN_SLOW];
      end
      // stop bit reads back while stopped
      stop_start <= (next_mode == STOP_MODE);
      if (wr_two) begin
         fast_osc_enable   <= hwdata[`BIT_FAST_OSC_EN];
         slow_osc_enable   <= hwdata[`BIT_SLOW_OSC_EN];
         main_clock_select <= hwdata[`BIT_MAIN_CLK_SEL];
      end
      if (wr_pend && wr_addr == `OFS_TICK_CONTROL)
         tick_timer_control <= hwdata[7:0];
      if (wr_pend && wr_addr == `OFS_IRQ_CONTROL) begin
         master_irq_enable <= hwdata[`BIT_MASTER_IRQ];
         tick_irq_enable   <= hwdata[`BIT_TICK_IRQ_EN];
      end
      // R13: latch on return; set beats write-one clear
      if (deep_halt && !(next_mode == DEEP_HALT_FAST || next_mode == DEEP_HALT_LOW) &&
          tick_en_at_entry)
         tick_irq_latch <= 1'b1;
      else if (wr_pend && wr_addr == `OFS_STATUS && hwdata[`BIT_TICK_LATCH])
         tick_irq_latch <= 1'b0;
   end
end

endmodule

// [verilog/clock_mode_regs.vh]
// register offsets, field positions, reset values and timing counts of the clock controller
`ifndef CLOCK_MODE_REGS_VH
`define CLOCK_MODE_REGS_VH
// byte offsets of the register words
`define OFS_SYS_CONTROL_ONE 8'h00
`define OFS_SYS_CONTROL_TWO 8'h04
`define OFS_TICK_CONTROL    8'h08
`define OFS_IRQ_CONTROL     8'h0C
`define OFS_STATUS          8'h10
// sys_control_one fields
`define BIT_STOP_START      7
`define BIT_RELEASE_LEVEL   6
`define BIT_RETURN_SLOW     5
// sys_control_two fields
`define BIT_FAST_OSC_EN     7
`define BIT_SLOW_OSC_EN     6
`define BIT_MAIN_CLK_SEL    5
`define BIT_IDLE            4
`define BIT_TG_HALT         2
`define SYS_TWO_RESET       8'h80
// tick_timer_control fields
`define BIT_STAGE7_SEL      7
`define BIT_TICK_EN         3
`define POS_TICK_SRC        0
// irq control fields
`define BIT_MASTER_IRQ      0
`define BIT_TICK_IRQ_EN     1
// status fields
`define POS_MODE            0
`define POS_MSTATE          4
`define BIT_TICK_LATCH      8
// divider shape and timing
`define PRESCALE_STAGES     2
`define DIVIDER_STAGES      21
`define MACHINE_STATES      4
`define WARMUP_STAGE        16
`endif

// [bench/clock_mode_checker.sv]
// port-level assertions for the system clock and mode controller
`timescale 1ns/1ps
module clock_mode_checker #(
   parameter WARMUP_STAGE = 16   // divider stage ending warm-up
) (
   input wire        hclk,
   input wire        hresetn,
   input wire        hreadyout,
   input wire        hresp,
   input wire        main_clk_en,
   input wire [1:0]  machine_state,
   input wire        cpu_run,
   input wire        periph_clk_en,
   input wire        tick_clk_en,
   input wire [22:0] divider_taps,
   input wire        fast_osc_on,
   input wire        slow_osc_on,
   input wire        xtal_pins_general,
   input wire        irq_accept,
   input wire        resume_next
);
   // both oscillators down happens in stop, or when software has cleared both oscillator enables
   wire stopped = !fast_osc_on && !slow_osc_on;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////
   a_bus_okay: assert property (
      hreadyout && !hresp) else $error("bus answer not ready or not okay");
   a_state_step: assert property (
      $changed(machine_state) |-> machine_state == $past(machine_state) + 2'd1)
      else $error("machine state skipped a step");
   a_clk_single: assert property (
      main_clk_en |=> !main_clk_en) else $error("main clock pulse too long");
   a_periph_gated: assert property (
      periph_clk_en |-> main_clk_en) else $error("peripheral pulse off main clock");
   a_tick_gated: assert property (
      tick_clk_en |-> main_clk_en) else $error("tick pulse off main clock");
   a_release_one: assert property (
      !(irq_accept && resume_next)) else $error("accept and resume together");
   a_run_release: assert property (
      (irq_accept || resume_next) |-> cpu_run) else $error("release without cpu run");
   a_stop_clear: assert property (
      stopped [*2] |-> divider_taps == 23'h000000 && !tick_clk_en && !cpu_run)
      else $error("divider or clocks alive in stop");
   a_dual_pins: assert property (
      slow_osc_on |-> !xtal_pins_general) else $error("crystal pins general in dual");
   // main scenarios reached
   c_accept: cover property (irq_accept);
   c_resume: cover property (resume_next);
   c_stop: cover property (stopped [*2]);
endmodule
bind system_clock_mode_controller clock_mode_checker #(
   .WARMUP_STAGE(WARMUP_STAGE)
) chk_inst (
   .hclk, .hresetn, .hreadyout, .hresp, .main_clk_en, .machine_state, .cpu_run,
   .periph_clk_en, .tick_clk_en, .divider_taps, .fast_osc_on, .slow_osc_on,
   .xtal_pins_general, .irq_accept, .resume_next
);

// [bench/osc_irq_model.sv]
// oscillators and interrupt source standing beside the clock controller
`timescale 1ns/1ps
module osc_irq_model (
   input  wire hclk,
   input  wire hresetn,
   input  wire fast_osc_on,   // fast oscillator allowed to run
   input  wire slow_osc_on,   // slow oscillator allowed to run
   input  wire irq_accept,
   input  wire resume_next,
   input  wire irq_raise,     // one-cycle request from the bench
   output reg  fast_clock,
   output reg  slow_clock,
   output reg  irq_request
);
   reg [3:0] cnt;             // free phase counter, unrelated to modes
   ////////////////////////////////////////////////////////////////
   // oscillators stop when disabled
   // fast period 4 hclk keeps it below half the bus clock
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 4'h0;
         fast_clock <= 1'b0;
         slow_clock <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         fast_clock <= fast_osc_on & cnt[1];
         slow_clock <= slow_osc_on & cnt[3];
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_request <= 1'b0;
      end else if (irq_raise) begin
         irq_request <= 1'b1;
      end else if (irq_accept || resume_next) begin
         irq_request <= 1'b0;
      end
   end
endmodule

// [bench/system_clock_mode_controller_tb.sv]
// register-level bench for the system clock and mode controller
`timescale 1ns/1ps
`include "clock_mode_regs.vh"
module system_clock_mode_controller_tb;
   reg         hclk, hresetn, hsel, hwrite, stop_pin_n, irq_raise;
   reg  [7:0]  haddr;
   reg  [1:0]  htrans;
   reg  [2:0]  hsize;
   reg  [31:0] hwdata, rd, snap;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, fast_clock, slow_clock, irq_request, main_clk_en;
   wire        cpu_run, periph_clk_en, tick_clk_en, fast_osc_on, slow_osc_on;
   wire        xtal_pins_general, irq_accept, resume_next, tick_irq_service;
   wire [1:0]  machine_state;
   wire [22:0] divider_taps;
   integer     n_fail, n_tests, n_acc, n_res, n_per, n_tick, i;
   ////////////////////////////////////////////////////////////////
   system_clock_mode_controller #(.WARMUP_STAGE(8)) system_clock_mode_controller_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fast_clock, .slow_clock,
      .stop_pin_n, .irq_request, .main_clk_en, .machine_state, .cpu_run,
      .periph_clk_en, .tick_clk_en, .divider_taps, .fast_osc_on, .slow_osc_on,
      .xtal_pins_general, .irq_accept, .resume_next, .tick_irq_service
   );
   osc_irq_model osc_irq_model_inst (
      .hclk, .hresetn, .fast_osc_on, .slow_osc_on, .irq_accept, .resume_next,
      .irq_raise, .fast_clock, .slow_clock, .irq_request
   );
   always #20 hclk = ~hclk;
   // release pulses counted from the pre-edge value
   always @(posedge hclk) begin
      if (irq_accept === 1'b1) n_acc = n_acc + 1;
      if (resume_next === 1'b1) n_res = n_res + 1;
   end
   ////////////////////////////////////////////////////////////////
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge hclk);
         #1;
      end
   endtask
   // single word transfer; signals move by nba at an edge, data taken at the edge
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge hclk);
         htrans <= 2'b10;
         haddr <= a;
         hwrite <= w;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         htrans <= 2'b00;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         rd = hrdata;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h00000000);
         check(rd, exp);
      end
   endtask
   // polls status until the mode code shows, bounded
   task wait_mode(input [3:0] m);
      begin
         i = 0;
         bus(1'b0, `OFS_STATUS, 32'h00000000);
         while (rd[3:0] !== m && i < 3000) begin
            bus(1'b0, `OFS_STATUS, 32'h00000000);
            i = i + 1;
         end
         check(rd[3:0], m);
      end
   endtask
   task count_pulses(input integer n);
      begin
         n_per = 0;
         n_tick = 0;
         repeat (n) begin
            tick(1);
            if (periph_clk_en === 1'b1) n_per = n_per + 1;
            if (tick_clk_en === 1'b1) n_tick = n_tick + 1;
         end
      end
   endtask
   task raise;
      begin
         @(posedge hclk);
         irq_raise <= 1'b1;
         @(posedge hclk);
         irq_raise <= 1'b0;
         #1;
      end
   endtask
   // run mode, halt on the idle strobe, interrupt back to run
   task halt_cycle(input [31:0] v, input [3:0] run, input [3:0] halt);
      begin
         wr(`OFS_SYS_CONTROL_TWO, v);
         wait_mode(run);
         wr(`OFS_SYS_CONTROL_TWO, v | 32'h00000010);
         wait_mode(halt);
         raise;
         wait_mode(run);
      end
   endtask
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // hang guard, well past the expected run length
   initial begin
      #2000000;
      n_fail = n_fail + 1;
      complete_run;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {hclk, hresetn, hwrite, irq_raise, haddr, htrans, hwdata} = 0;
      {n_fail, n_tests, n_acc, n_res} = 0;
      hsel = 1'b1;
      hsize = 3'b010;
      stop_pin_n = 1'b1;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      tick(1);
      wait_mode(4'h0);
      rdc(`OFS_SYS_CONTROL_TWO, 32'h00000080);
      rdc(8'h20, 32'h00000000);
      wr(8'h20, 32'hFFFFFFFF);
      rdc(`OFS_SYS_CONTROL_ONE, 32'h00000000);
      check(xtal_pins_general, 1);
      count_pulses(40);
      check(n_per >= 9 && n_per <= 11, 1);
      // halt and release, with and without the master enable
      wr(`OFS_IRQ_CONTROL, 32'h00000001);
      halt_cycle(32'h00000080, 4'h0, 4'h1);
      tick(4);
      check(n_acc, 1);
      wr(`OFS_IRQ_CONTROL, 32'h00000000);
      halt_cycle(32'h00000080, 4'h0, 4'h1);
      tick(4);
      check(n_res, 1);
      // slow oscillator started first, stage-seven select never set
      wr(`OFS_SYS_CONTROL_TWO, 32'h000000C0);
      wait_mode(4'h3);
      check(xtal_pins_general, 0);
      halt_cycle(32'h000000C0, 4'h3, 4'h4);
      halt_cycle(32'h000000E0, 4'h5, 4'h7);
      halt_cycle(32'h00000060, 4'h6, 4'h8);
      check(fast_osc_on, 0);
      snap = divider_taps;
      count_pulses(160);
      check(n_per >= 9 && n_per <= 11, 1);
      check(divider_taps[7:2], snap[7:2]);
      // deep halt from low run, tick timer enabled
      wr(`OFS_TICK_CONTROL, 32'h0000000F);
      wr(`OFS_IRQ_CONTROL, 32'h00000003);
      wr(`OFS_SYS_CONTROL_TWO, 32'h00000064);
      tick(100);
      wait_mode(4'h6);
      check(rd[8], 1);
      wr(`OFS_STATUS, 32'h00000100);
      wait_mode(4'h6);
      check(rd[8], 0);
      // deep halt from fast dual run
      halt_cycle(32'h000000E0, 4'h5, 4'h7);
      halt_cycle(32'h000000C0, 4'h3, 4'h4);
      wr(`OFS_SYS_CONTROL_TWO, 32'h000000C4);
      wait_mode(4'h2);
      count_pulses(40);
      check(n_per, 0);
      check(n_tick != 0, 1);
      wait_mode(4'h3);
      check(rd[8], 1);
      check(tick_irq_service, 1);
      wr(`OFS_STATUS, 32'h00000100);
      // stop with level release on the pin
      wr(`OFS_SYS_CONTROL_ONE, 32'h000000C0);
      wait_mode(4'hA);
      check(divider_taps, 0);
      stop_pin_n <= 1'b0;
      wait_mode(4'h3);
      stop_pin_n <= 1'b1;
      tick(2);
      complete_run;
   end
endmodule
